//--- core/remote_bus_pkg.sv
// constants, types and keyword table of the remote bus command parser
package remote_bus_pkg;
  localparam int KW_MAX = 10;
  localparam int PATH_DEPTH = 4;
  localparam int NKW = 13;
  localparam logic [4:0] DEF_ADDR = 5'h03;
  localparam logic [4:0] ADDR_MAX = 5'h1e;
  localparam logic DEF_TALK_ONLY = 1'b0;
  localparam logic [1:0] CHAN_DEFAULT = 2'h1;
  localparam logic [1:0] CHAN_TWO = 2'h2;
  localparam logic [3:0] KLEN_ONE = 4'h1;
  localparam logic [2:0] DEPTH_ONE = 3'h1;

  // ascii codes
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_HEADER_PARAMETER_GAP = 8'h20;
  localparam logic [7:0] CH_COMMA = 8'h2c;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_DIG0 = 8'h30;
  localparam logic [7:0] CH_DIG1 = 8'h31;
  localparam logic [7:0] CH_DIG2 = 8'h32;
  localparam logic [7:0] CH_DIG9 = 8'h39;
  localparam logic [7:0] CH_UP_A = 8'h41;
  localparam logic [7:0] CH_UP_Z = 8'h5a;
  localparam logic [7:0] CH_LO_A = 8'h61;
  localparam logic [7:0] CH_LO_Z = 8'h7a;
  localparam logic [7:0] CASE_OFFSET = 8'h20;

  typedef enum logic [3:0] {
    KW_NONE, KW_SENSE, KW_FREQ, KW_ARM, KW_STOP, KW_SOURCE, KW_INPUT,
    KW_COUPLING, KW_CALC, KW_RST, KW_IDN, KW_CLS, KW_RCL
  } kw_id_t;

  // full spellings, right-justified: last letter in bits 7:0
  localparam logic [79:0] KW_TEXT [NKW] = '{
    80'h0, "SENSE", "FREQUENCY", "ARM", "STOP", "SOURCE", "INPUT",
    "COUPLING", "CALCULATE", "RST", "IDN", "CLS", "RCL"};
  localparam logic [3:0] KW_FULL_LEN [NKW] = '{
    4'h0, 4'h5, 4'h9, 4'h3, 4'h4, 4'h6, 4'h5, 4'h8, 4'h9, 4'h3, 4'h3, 4'h3, 4'h3};
  localparam logic [3:0] KW_SHORT_LEN [NKW] = '{
    4'h0, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h3};
  // bit n set: keyword n is a child of the optional root keyword
  localparam logic [NKW-1:0] KW_SENSE_CHILD = 13'h0004;
  localparam logic [NKW-1:0] KW_SUFFIX_OK = 13'h0040;
  localparam logic [NKW-1:0] KW_COMMON = 13'h1e00;

  typedef enum logic [1:0] {P_HDR, P_PARAM, P_SKIP} parse_st_t;
  typedef enum logic [1:0] {ERR_NONE, ERR_KEYWORD, ERR_SYNTAX, ERR_OVERFLOW} err_t;

  typedef struct packed {
    kw_id_t id;
    logic [1:0] chan;
    logic sfx;
  } kw_hit_t;

  typedef struct packed {
    logic common;
    logic query;
    logic [1:0] chan;
    logic [2:0] depth;
    kw_id_t [PATH_DEPTH-1:0] path;
  } hdr_t;

  typedef struct packed {
    parse_st_t st;
    logic talk_only;
    logic [4:0] addr;
    logic remote;
    logic [2:0] key_sync;
    logic [KW_MAX-1:0][7:0] kbuf;
    logic [3:0] klen;
    logic seen;
    hdr_t hdr;
    hdr_t hdr_out;
    logic hdr_valid;
    logic [7:0] param_byte;
    logic param_valid;
    logic param_sep;
    logic msg_end;
    logic err;
    err_t err_code;
    logic refused;
    logic panel_valid;
    logic [7:0] panel_code;
  } state_t;
endpackage

//--- core/remote_bus_command_parser.sv
// bus mode/address store, remote/local control and program message parser
// Summary of operation
// - address 0..30 selects addressed talk/listen; commands accepted, data returned
// - talk-only mode transmits to a printer and refuses every incoming byte
// - factory default: addressed mode, bus address 3
// - mode and address survive remote interface clear; power-up reset restores the factory default
// - power-up lands in local state with the front panel in charge
// - in remote state front-panel setting changes are dropped
// - local key returns to local only without local lockout
// - leading asterisk marks a common command; parameter follows a space
// - headers, data and terminators arrive as ascii bytes, parsed in order
// - colon separates a keyword from the next lower keyword
// - each keyword accepted in short or full spelling
// - any other spelling is rejected with an error
// - keyword matching ignores letter case
// - an omitted optional keyword is treated as present
// - missing channel suffix selects channel 1; suffix may be 1 or 2
`timescale 1ns/100ps
`default_nettype none
module remote_bus_command_parser #(
  parameter logic [4:0] FACTORY_ADDR = remote_bus_pkg::DEF_ADDR
) (
  input wire logic i_clock, // 40 MHz system clock
  input wire logic i_sys_rst, // async reset, active high (power-up)
  input wire logic i_rx_valid, // received bus byte strobe
  input wire logic [7:0] i_rx_byte, // received bus byte
  input wire logic i_rx_eoi, // end-or-identify with this byte
  output logic o_rx_ready, // bytes are accepted
  output logic o_rx_refused, // byte dropped in talk-only mode
  input wire logic i_cfg_store, // panel enter: store mode/address
  input wire logic i_cfg_talk_only, // requested talk-only mode
  input wire logic [4:0] i_cfg_addr, // requested bus address
  output logic o_talk_only, // talk-only mode active
  output logic [4:0] o_bus_addr, // stored bus address
  output logic o_listen_enable, // device may be addressed to listen
  input wire logic i_ren, // remote enable from bus logic
  input wire logic i_listen_addressed, // addressed to listen
  input wire logic i_llo, // local lockout in effect
  input wire logic i_local_key, // local-return key pin
  output logic o_remote, // remote state
  input wire logic i_panel_valid, // front-panel setting change
  input wire logic [7:0] i_panel_code, // setting change code
  output logic o_panel_valid, // forwarded setting change
  output logic [7:0] o_panel_code, // forwarded code
  output remote_bus_pkg::hdr_t o_hdr, // parsed header
  output logic o_hdr_valid, // header complete pulse
  output logic [7:0] o_param_byte, // parameter byte
  output logic o_param_valid, // parameter byte pulse
  output logic o_param_sep, // comma between parameters pulse
  output logic o_msg_end, // message terminator pulse
  output logic o_error, // parse error pulse
  output remote_bus_pkg::err_t o_error_code // kind of error
);
  import remote_bus_pkg::*;

  if (FACTORY_ADDR > ADDR_MAX) begin : g_addr_check
    $error("factory bus address out of range");
  end

  state_t s_q;
  state_t s_d;

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    if (c >= CH_LO_A && c <= CH_LO_Z) begin
      return c - CASE_OFFSET;
    end
    return c;
  endfunction

  function automatic logic is_word_char(input logic [7:0] c);
    return (c >= CH_UP_A && c <= CH_UP_Z) || (c >= CH_DIG0 && c <= CH_DIG9);
  endfunction

  // short or full spelling only; prefixes of other lengths miss
  function automatic kw_id_t kw_lookup(input logic [KW_MAX-1:0][7:0] kb, input logic [3:0] kl);
    kw_id_t id;
    logic ok;
    id = KW_NONE;
    for (int i = 1; i < NKW; i++) begin
      ok = (kl == KW_FULL_LEN[i]) || (kl == KW_SHORT_LEN[i]);
      for (int k = 0; k < KW_MAX; k++) begin
        if (k < int'(kl) && k < int'(KW_FULL_LEN[i])) begin
          if (kb[k] != KW_TEXT[i][(int'(KW_FULL_LEN[i]) - 1 - k) * 8 +: 8]) begin
            ok = 1'b0;
          end
        end
      end
      if (ok) begin
        id = kw_id_t'(i);
      end
    end
    return id;
  endfunction

  function automatic kw_hit_t kw_resolve(input logic [KW_MAX-1:0][7:0] kb, input logic [3:0] kl);
    kw_hit_t r;
    kw_id_t stripped;
    logic [7:0] last;
    r.id = kw_lookup(kb, kl);
    r.chan = CHAN_DEFAULT;
    r.sfx = 1'b0;
    last = kb[kl - KLEN_ONE];
    if (kl > KLEN_ONE && (last == CH_DIG1 || last == CH_DIG2)) begin
      stripped = kw_lookup(kb, kl - KLEN_ONE);
      if (KW_SUFFIX_OK[stripped]) begin
        r.id = stripped;
        r.sfx = 1'b1;
        r.chan = (last == CH_DIG2) ? CHAN_TWO : CHAN_DEFAULT;
      end
    end
    return r;
  endfunction

  always_comb begin
    hdr_t h;
    kw_hit_t hit;
    logic [KW_MAX-1:0][7:0] kb;
    logic [3:0] kl;
    logic [7:0] c;
    logic term;
    logic bad;
    logic close;
    h = s_q.hdr;
    hit = '0;
    kb = s_q.kbuf;
    kl = s_q.klen;
    c = to_upper(i_rx_byte);
    term = (i_rx_byte == CH_LF) || i_rx_eoi;
    bad = 1'b0;
    close = 1'b0;
    s_d = s_q;
    s_d.hdr_valid = 1'b0;
    s_d.param_valid = 1'b0;
    s_d.param_sep = 1'b0;
    s_d.msg_end = 1'b0;
    s_d.err = 1'b0;
    s_d.refused = 1'b0;
    s_d.panel_valid = 1'b0;

    // an out-of-range address with addressed mode is not taken; the stored pair stays as it was
    if (i_cfg_store && (i_cfg_talk_only || i_cfg_addr <= ADDR_MAX)) begin
      s_d.talk_only = i_cfg_talk_only;
      s_d.addr = i_cfg_addr;
    end

    s_d.key_sync = {s_q.key_sync[1:0], i_local_key};
    if (s_q.talk_only || !i_ren) begin
      s_d.remote = 1'b0;
    end else if (i_listen_addressed) begin
      s_d.remote = 1'b1;
    end else if (s_q.key_sync[1] && !s_q.key_sync[2] && !i_llo) begin
      s_d.remote = 1'b0;
    end

    if (i_panel_valid && !s_q.remote) begin
      s_d.panel_valid = 1'b1;
      s_d.panel_code = i_panel_code;
    end

    if (i_rx_valid && s_q.talk_only) begin
      s_d.refused = 1'b1;
    end else if (i_rx_valid) begin
      case (s_q.st)
        P_HDR: begin
          if (c == CH_STAR && !s_q.seen) begin
            h.common = 1'b1;
          end else if (is_word_char(c)) begin
            if (int'(kl) < KW_MAX) begin
              kb[kl] = c;
              kl = kl + KLEN_ONE;
            end else begin
              bad = 1'b1;
              s_d.err_code = ERR_OVERFLOW;
            end
          end else if (c == CH_COLON) begin
            close = 1'b1;
            if (h.common) begin
              bad = 1'b1;
              s_d.err_code = ERR_SYNTAX;
            end
          end else if (c == CH_QUERY) begin
            close = 1'b1;
            h.query = 1'b1;
          end else if (c == CH_HEADER_PARAMETER_GAP || c == CH_SEMI || term) begin
            close = 1'b1;
          end else begin
            bad = 1'b1;
            s_d.err_code = ERR_SYNTAX;
          end
          close = (close || term) && !bad;
          if (close && kl != '0) begin
            hit = kw_resolve(kb, kl);
            if (hit.id != KW_NONE && KW_COMMON[hit.id] == h.common && int'(h.depth) < PATH_DEPTH) begin
              h.path[h.depth] = hit.id;
              h.depth = h.depth + DEPTH_ONE;
              if (hit.sfx) begin
                h.chan = hit.chan;
              end
            end else begin
              bad = 1'b1;
              s_d.err_code = ERR_KEYWORD;
            end
            kl = '0;
          end
          s_d.seen = 1'b1;
          s_d.kbuf = kb;
          s_d.klen = kl;
          s_d.hdr = h;
          if (bad) begin
            s_d.err = 1'b1;
            s_d.st = P_SKIP;
          end else if (close && (c == CH_HEADER_PARAMETER_GAP || c == CH_SEMI || term)) begin
            // root left out: insert it so the path reads as if it was sent
            if (h.depth != '0 && KW_SENSE_CHILD[h.path[0]] && int'(h.depth) < PATH_DEPTH) begin
              h.path = {h.path[PATH_DEPTH-2:0], KW_SENSE};
              h.depth = h.depth + DEPTH_ONE;
            end
            s_d.hdr_out = h;
            s_d.hdr_valid = h.depth != '0;
            s_d.hdr = '0;
            s_d.hdr.chan = CHAN_DEFAULT;
            s_d.seen = 1'b0;
            if (c == CH_HEADER_PARAMETER_GAP && !term) begin
              s_d.st = P_PARAM;
            end
          end
          if (term) begin
            s_d.msg_end = 1'b1;
            s_d.st = P_HDR;
            s_d.hdr = '0;
            s_d.hdr.chan = CHAN_DEFAULT;
            s_d.seen = 1'b0;
            s_d.klen = '0;
          end
        end
        P_PARAM: begin
          // quoted strings holding ';' or ',' are not recognised as such
          if (i_rx_byte == CH_LF) begin
            s_d.msg_end = 1'b1;
            s_d.st = P_HDR;
          end else if (i_rx_byte == CH_COMMA) begin
            s_d.param_sep = 1'b1;
          end else if (i_rx_byte == CH_SEMI) begin
            s_d.st = P_HDR;
          end else begin
            s_d.param_valid = 1'b1;
            s_d.param_byte = i_rx_byte;
          end
          if (i_rx_eoi) begin
            s_d.msg_end = 1'b1;
            s_d.st = P_HDR;
          end
        end
        P_SKIP: begin
          if (term) begin
            s_d.msg_end = 1'b1;
            s_d.st = P_HDR;
            s_d.hdr = '0;
            s_d.hdr.chan = CHAN_DEFAULT;
            s_d.seen = 1'b0;
            s_d.klen = '0;
          end
        end
        default: begin
          s_d.st = P_HDR;
        end
      endcase
    end
  end

  // only power-up reset reaches mode/address; there is no interface-clear input
  always_ff @(posedge i_clock or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      s_q <= '0;
      s_q.talk_only <= DEF_TALK_ONLY;
      s_q.addr <= FACTORY_ADDR;
      s_q.remote <= 1'b0;
      s_q.hdr.chan <= CHAN_DEFAULT;
      s_q.st <= P_HDR;
      s_q.err_code <= ERR_NONE;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_rx_ready = !s_q.talk_only;
  assign o_rx_refused = s_q.refused;
  assign o_talk_only = s_q.talk_only;
  assign o_bus_addr = s_q.addr;
  assign o_listen_enable = !s_q.talk_only;
  assign o_remote = s_q.remote;
  assign o_panel_valid = s_q.panel_valid;
  assign o_panel_code = s_q.panel_code;
  assign o_hdr = s_q.hdr_out;
  assign o_hdr_valid = s_q.hdr_valid;
  assign o_param_byte = s_q.param_byte;
  assign o_param_valid = s_q.param_valid;
  assign o_param_sep = s_q.param_sep;
  assign o_msg_end = s_q.msg_end;
  assign o_error = s_q.err;
  assign o_error_code = s_q.err_code;
endmodule
`default_nettype wire

//--- test/remote_bus_controller_model.sv
// behavioural bus controller that feeds program message bytes
`timescale 1ns/100ps
`default_nettype none
module remote_bus_controller_model (
  input wire logic i_clock, // clk
  output logic o_valid, // byte strobe
  output logic [7:0] o_byte, // ascii byte
  output logic o_eoi // end marker
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h55;
    o_eoi = 1'b0;
  end
  // gap idles the strobe between bytes to mimic a slow controller
  task automatic send(input string s, input bit eoi_last, input int gap);
    for (int i = 0; i < s.len(); i++) begin
      if (gap > 0 && i > 0) begin
        @(negedge i_clock);
        o_valid <= 1'b0;
        o_byte <= ~o_byte;
        repeat (gap - 1) @(negedge i_clock);
      end
      @(negedge i_clock);
      o_valid <= 1'b1;
      o_byte <= s[i];
      o_eoi <= eoi_last && (i == s.len() - 1);
    end
    @(negedge i_clock);
    o_valid <= 1'b0;
    o_eoi <= 1'b0;
    // released bus must not keep showing the last byte
    o_byte <= ~o_byte;
  endtask
endmodule
`default_nettype wire

//--- test/remote_bus_command_parser_assertions.sv
// port-level checks for the remote bus command parser
`timescale 1ns/100ps
`default_nettype none
module remote_bus_command_parser_assertions (
  input wire logic i_clock, // clk
  input wire logic i_sys_rst, // rst
  input wire logic i_rx_valid, // strobe
  input wire logic [7:0] i_rx_byte, // byte
  input wire logic i_rx_eoi, // end
  input wire logic o_rx_ready, // ready
  input wire logic o_rx_refused, // refused
  input wire logic i_cfg_store, // store
  input wire logic i_cfg_talk_only, // mode
  input wire logic [4:0] i_cfg_addr, // addr
  input wire logic o_talk_only, // mode
  input wire logic [4:0] o_bus_addr, // addr
  input wire logic o_listen_enable, // listen
  input wire logic i_ren, // ren
  input wire logic i_llo, // lockout
  input wire logic o_remote, // remote
  input wire logic i_panel_valid, // panel
  input wire logic [7:0] i_panel_code, // code
  input wire logic o_panel_valid, // panel
  input wire logic [7:0] o_panel_code, // code
  input wire remote_bus_pkg::hdr_t o_hdr, // header
  input wire logic o_hdr_valid, // header pulse
  input wire logic o_param_valid, // param pulse
  input wire logic o_msg_end, // end pulse
  input wire logic o_error // error pulse
);
  import remote_bus_pkg::*;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  property p_mode_levels;
    o_rx_ready == !o_talk_only && o_listen_enable == !o_talk_only;
  endproperty
  a_mode_levels: assert property (p_mode_levels) else $error("ready or listen disagrees with mode");
  property p_refuse;
    i_rx_valid |=> o_rx_refused == $past(o_talk_only);
  endproperty
  a_refuse: assert property (p_refuse) else $error("refusal pulse wrong");
  property p_talk_silent;
    i_rx_valid && o_talk_only |=> !o_hdr_valid && !o_param_valid && !o_msg_end;
  endproperty
  a_talk_silent: assert property (p_talk_silent) else $error("talk-only byte was parsed");
  property p_addr_legal;
    !o_talk_only |-> o_bus_addr <= ADDR_MAX;
  endproperty
  a_addr_legal: assert property (p_addr_legal) else $error("addressed mode with illegal address");
  property p_cfg_take;
    i_cfg_store && i_cfg_addr <= ADDR_MAX |=> o_bus_addr == $past(i_cfg_addr) && o_talk_only == $past(i_cfg_talk_only);
  endproperty
  a_cfg_take: assert property (p_cfg_take) else $error("config not stored");
  property p_cfg_drop;
    i_cfg_store && !i_cfg_talk_only && i_cfg_addr > ADDR_MAX |=> $stable(o_bus_addr) && $stable(o_talk_only);
  endproperty
  a_cfg_drop: assert property (p_cfg_drop) else $error("address 31 accepted");
  property p_panel_block;
    i_panel_valid && o_remote |=> !o_panel_valid;
  endproperty
  a_panel_block: assert property (p_panel_block) else $error("panel change passed in remote");
  property p_panel_pass;
    i_panel_valid && !o_remote |=> o_panel_valid && o_panel_code == $past(i_panel_code);
  endproperty
  a_panel_pass: assert property (p_panel_pass) else $error("panel change lost in local");
  property p_lockout;
    o_remote && i_ren && i_llo && !o_talk_only |=> o_remote;
  endproperty
  a_lockout: assert property (p_lockout) else $error("left remote under lockout");
  property p_msg_end;
    i_rx_valid && o_rx_ready && (i_rx_byte == CH_LF || i_rx_eoi) |=> o_msg_end;
  endproperty
  a_msg_end: assert property (p_msg_end) else $error("terminator not reported");
  property p_chan;
    o_hdr_valid |-> o_hdr.chan == CHAN_DEFAULT || o_hdr.chan == CHAN_TWO;
  endproperty
  a_chan: assert property (p_chan) else $error("header channel out of range");
  c_common: cover property (o_hdr_valid && o_hdr.common);
  c_refused: cover property (o_rx_refused);
  c_local: cover property ($fell(o_remote));
  c_error: cover property (o_error);
endmodule
`default_nettype wire
bind remote_bus_command_parser remote_bus_command_parser_assertions chk (.i_clock, .i_sys_rst, .i_rx_valid,
  .i_rx_byte, .i_rx_eoi, .o_rx_ready, .o_rx_refused, .i_cfg_store, .i_cfg_talk_only, .i_cfg_addr, .o_talk_only,
  .o_bus_addr, .o_listen_enable, .i_ren, .i_llo, .o_remote, .i_panel_valid, .i_panel_code, .o_panel_valid,
  .o_panel_code, .o_hdr, .o_hdr_valid, .o_param_valid, .o_msg_end, .o_error);

//--- test/remote_bus_command_parser_test.sv
// self-checking bench for the remote bus command parser
`timescale 1ns/100ps
`default_nettype none
module remote_bus_command_parser_test;
  import remote_bus_pkg::*;
  logic i_clock = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_cfg_store = 1'b0, i_cfg_talk_only = 1'b0, i_ren = 1'b0, i_listen_addressed = 1'b0;
  logic i_llo = 1'b0, i_local_key = 1'b0, i_panel_valid = 1'b0, i_rx_valid, i_rx_eoi;
  logic o_rx_ready, o_rx_refused, o_talk_only, o_listen_enable, o_remote, o_panel_valid;
  logic o_hdr_valid, o_param_valid, o_param_sep, o_msg_end, o_error;
  logic [7:0] i_rx_byte, i_panel_code = 8'h00, o_panel_code, o_param_byte, last_panel;
  logic [4:0] i_cfg_addr = 5'h00, o_bus_addr;
  hdr_t o_hdr, last_hdr;
  err_t o_error_code;
  int n_fail, num_checks, n_hdr, n_sep, n_end, n_err, n_ref, n_pnl;
  string params;
  string bad[4] = '{"calcu 1\n", "CALCULA 1\n", "*cls:x\n", "frequencyab\n"};
  err_t bad_code[4] = '{ERR_KEYWORD, ERR_KEYWORD, ERR_SYNTAX, ERR_OVERFLOW};

  always #12.5 i_clock = ~i_clock;

  remote_bus_controller_model ctl (.i_clock, .o_valid(i_rx_valid), .o_byte(i_rx_byte), .o_eoi(i_rx_eoi));
  remote_bus_command_parser uut (.i_clock, .i_sys_rst, .i_rx_valid, .i_rx_byte, .i_rx_eoi, .o_rx_ready,
    .o_rx_refused, .i_cfg_store, .i_cfg_talk_only, .i_cfg_addr, .o_talk_only, .o_bus_addr, .o_listen_enable,
    .i_ren, .i_listen_addressed, .i_llo, .i_local_key, .o_remote, .i_panel_valid, .i_panel_code,
    .o_panel_valid, .o_panel_code, .o_hdr, .o_hdr_valid, .o_param_byte, .o_param_valid, .o_param_sep,
    .o_msg_end, .o_error, .o_error_code);

  // pulses are single-cycle, so tally them at every edge
  always @(posedge i_clock) begin
    if (o_hdr_valid === 1'b1) begin
      last_hdr = o_hdr;
      n_hdr++;
    end
    if (o_param_valid === 1'b1) params = $sformatf("%s%c", params, o_param_byte);
    if (o_param_sep === 1'b1) n_sep++;
    if (o_msg_end === 1'b1) n_end++;
    if (o_error === 1'b1) n_err++;
    if (o_rx_refused === 1'b1) n_ref++;
    if (o_panel_valid === 1'b1) begin
      last_panel = o_panel_code;
      n_pnl++;
    end
  end

  // wide enough for three packed counters, so none is cut off
  task automatic cmp(input logic [95:0] g, input logic [95:0] e, input string m);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  function automatic hdr_t mk(logic c, logic q, logic [1:0] ch, logic [2:0] d, kw_id_t k0,
    kw_id_t k1 = KW_NONE, kw_id_t k2 = KW_NONE, kw_id_t k3 = KW_NONE);
    mk = {c, q, ch, d, k3, k2, k1, k0};
  endfunction

  task automatic msg(input string s, input bit eoi = 1'b0, input int gap = 0);
    {n_hdr, n_sep, n_end, n_err, n_ref} = '0;
    params = "";
    ctl.send(s, eoi, gap);
    repeat (3) @(negedge i_clock);
  endtask

  task automatic cfg(input logic t, input logic [4:0] a);
    @(negedge i_clock);
    i_cfg_store = 1'b1;
    i_cfg_talk_only = t;
    i_cfg_addr = a;
    @(negedge i_clock);
    i_cfg_store = 1'b0;
    @(negedge i_clock);
  endtask

  task automatic panel(input logic [7:0] c);
    n_pnl = 0;
    @(negedge i_clock);
    i_panel_valid = 1'b1;
    i_panel_code = c;
    @(negedge i_clock);
    i_panel_valid = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask

  // key goes through a synchroniser, so hold it well past its delay
  task automatic press(input logic lockout);
    i_llo = lockout;
    i_local_key = 1'b1;
    repeat (6) @(negedge i_clock);
    i_local_key = 1'b0;
    repeat (2) @(negedge i_clock);
  endtask

  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // whole run is well under 2000 cycles
  initial begin
    #(8000 * 25);
    n_fail++;
    stop_test();
  end

  initial begin
    repeat (5) @(negedge i_clock);
    i_sys_rst = 1'b0;
    cmp({o_talk_only, o_bus_addr}, {DEF_TALK_ONLY, DEF_ADDR}, "factory config");
    cmp({o_remote, o_rx_ready, o_listen_enable}, 3'h3, "power-up state");
    msg("inp2:coup AC\n");
    cmp(last_hdr, mk(1'b0, 1'b0, CHAN_TWO, 3'h2, KW_INPUT, KW_COUPLING), "suffix header");
    cmp({n_hdr, n_end, n_err}, {32'd1, 32'd1, 32'd0}, "message counts");
    cmp(params == "AC", 1'b1, "params");
    msg("INPUT:COUPLING DC,AC\n", 1'b0, 2);
    cmp(last_hdr, mk(1'b0, 1'b0, CHAN_DEFAULT, 3'h2, KW_INPUT, KW_COUPLING), "full header");
    cmp({n_sep, 32'(params == "DCAC")}, {32'd1, 32'd1}, "separator");
    msg("freq:arm:stop 1\n");
    cmp(last_hdr, mk(1'b0, 1'b0, CHAN_DEFAULT, 3'h4, KW_SENSE, KW_FREQ, KW_ARM, KW_STOP), "implied root");
    msg("SeNsE:FrEq:ArM:StOp 1\n");
    cmp(last_hdr, mk(1'b0, 1'b0, CHAN_DEFAULT, 3'h4, KW_SENSE, KW_FREQ, KW_ARM, KW_STOP), "mixed case");
    foreach (bad[i]) begin
      msg(bad[i]);
      cmp({n_err, n_hdr, n_end}, {32'd1, 32'd0, 32'd1}, "bad spelling");
      cmp(o_error_code, bad_code[i], "error code");
    end
    msg("*RCL 1\n");
    cmp(last_hdr, mk(1'b1, 1'b0, CHAN_DEFAULT, 3'h1, KW_RCL), "common header");
    cmp(params == "1", 1'b1, "common param");
    msg("*rst;*cls\n");
    cmp({n_hdr, n_end}, {32'd2, 32'd1}, "two headers");
    cmp(last_hdr, mk(1'b1, 1'b0, CHAN_DEFAULT, 3'h1, KW_CLS), "second header");
    msg("*idn?", 1'b1);
    cmp(last_hdr, mk(1'b1, 1'b1, CHAN_DEFAULT, 3'h1, KW_IDN), "eoi query");
    cmp(n_end, 1, "eoi end");
    i_ren = 1'b1;
    i_listen_addressed = 1'b1;
    repeat (2) @(negedge i_clock);
    i_listen_addressed = 1'b0;
    cmp(o_remote, 1'b1, "remote");
    panel(8'h3c);
    cmp(n_pnl, 0, "panel in remote");
    press(1'b1);
    cmp(o_remote, 1'b1, "lockout key");
    press(1'b0);
    cmp(o_remote, 1'b0, "local key");
    panel(8'h5a);
    cmp({n_pnl, 24'h0, last_panel}, {32'd1, 32'h5a}, "panel in local");
    i_ren = 1'b0;
    cfg(1'b0, 5'h1e);
    cmp({o_talk_only, o_bus_addr}, 6'h1e, "address 30");
    cfg(1'b0, 5'h1f);
    cmp({o_talk_only, o_bus_addr}, 6'h1e, "address 31 ignored");
    cfg(1'b1, 5'h1f);
    cmp({o_talk_only, o_rx_ready, o_listen_enable}, 3'h4, "talk-only");
    msg("*cls\n");
    cmp({n_ref, n_hdr, n_end}, {32'd5, 32'd0, 32'd0}, "talk-only refusal");
    cfg(1'b0, DEF_ADDR);
    cmp(o_rx_ready, 1'b1, "addressed again");
    stop_test();
  end
endmodule
`default_nettype wire
